// ---- rtl/pif_pkg.sv ----
// Package of constants and types for the peripheral flag block.
// Functional notes
// - Flags set regardless of any enable.
// - Flag register A layout, reset zero.
// - Receive and transmit flags are read-only levels.
// - Parallel port flag sticky until cleared.
// - Conversion flag set on conversion complete.
// - Serial port flag set on port events.
// - Capture/compare flags set, unused in PWM.
// - Period match flag sticky until cleared.
// - Timer one overflow flag sticky.
// - Enable register B layout, reset zero.
// - Flag register B layout, reset zero.
// - EEPROM flag set when write finishes.
// - Collision flag set on bus collision.
// - Reset cause holds two status bits.
// - Power-on reset clears its status bit.
// - Brown-out reset clears its status bit.
// - Brown-out bit undefined when detection off.
// - Enable register A mirrors flag register A.
// - Peripheral enable gates every peripheral request.
// - Global enable gates every request.
package pif_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_CTRL    = 8'h0b;
   localparam logic [7:0] IDX_FLAGS_A = 8'h0c;
   localparam logic [7:0] IDX_FLAGS_B = 8'h0d;
   localparam logic [7:0] IDX_EN_A    = 8'h8c;
   localparam logic [7:0] IDX_EN_B    = 8'h8d;
   localparam logic [7:0] IDX_CAUSE   = 8'h8e;
   // Bit positions.
   localparam int FA_PSP  = 7;
   localparam int FA_CONV = 6;
   localparam int FA_RX   = 5;
   localparam int FA_TX   = 4;
   localparam int FA_SSP  = 3;
   localparam int FA_CCP1 = 2;
   localparam int FA_PR   = 1;
   localparam int FA_T1   = 0;
   localparam int FB_EE   = 4;
   localparam int FB_COL  = 3;
   localparam int FB_CCP2 = 0;
   localparam int RC_POR  = 1;
   localparam int RC_BOR  = 0;
   localparam int CT_GIE  = 7;
   localparam int CT_PERIPHERAL_IRQ_ENABLE = 6;
   // Writable masks and reset values.
   localparam logic [7:0] FA_WR_MASK  = 8'hcf;
   localparam logic [7:0] FB_MASK     = 8'h59;
   localparam logic [7:0] CAUSE_MASK  = 8'h03;
   localparam logic [7:0] CTRL_MASK   = 8'hc0;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] FLAGS_A_RST = 8'h00;
   localparam logic [7:0] FLAGS_B_RST = 8'h00;
   localparam logic [7:0] EN_A_RST    = 8'h00;
   localparam logic [7:0] EN_B_RST    = 8'h00;
   localparam logic [7:0] CAUSE_RST   = 8'h01;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Event and level inputs from the peripherals.
   typedef struct packed {
      logic psp_access;
      logic conv_done;
      logic rx_full;
      logic tx_empty;
      logic ssp_event;
      logic ccp1_event;
      logic ccp1_pwm;
      logic period_match;
      logic t1_overflow;
      logic ee_done;
      logic collision;
      logic ccp2_event;
      logic ccp2_pwm;
   } pif_events_t;

   // Reset cause sources.
   typedef struct packed {
      logic por_event;
      logic bor_event;
      logic bod_enable;
   } pif_rst_src_t;

   // Whole state of the block.
   typedef struct packed {
      logic        aw_held;
      logic [7:0]  aw_idx;
      logic        w_held;
      logic [7:0]  w_data;
      logic        w_lane;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  ctrl;
      logic [7:0]  fl_a;
      logic [7:0]  en_a;
      logic [7:0]  fl_b;
      logic [7:0]  en_b;
      logic [7:0]  cause;
      logic        irq;
   } pif_state_t;
endpackage

// ---- rtl/pif_top.sv ----
// Peripheral flag, enable and reset cause registers behind AXI4-Lite.
`timescale 1ns/1ns
module pif_top (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [9:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [9:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire pif_pkg::pif_events_t ev,
   input  wire pif_pkg::pif_rst_src_t rst_src,
   output logic                      irq_out
);
   import pif_pkg::*;

   pif_state_t s_reg;
   pif_state_t s_next;
   logic       do_wr;
   logic       wr_hit;
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] rd_val;
   logic       rd_hit;

   // Read multiplexer on the address being accepted.
   always_comb begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      if (s_axi_araddr[9:2] == IDX_CTRL) begin
         rd_val = s_reg.ctrl;
      end else if (s_axi_araddr[9:2] == IDX_FLAGS_A) begin
         rd_val = s_reg.fl_a;
      end else if (s_axi_araddr[9:2] == IDX_FLAGS_B) begin
         rd_val = s_reg.fl_b & FB_MASK;
      end else if (s_axi_araddr[9:2] == IDX_EN_A) begin
         rd_val = s_reg.en_a;
      end else if (s_axi_araddr[9:2] == IDX_EN_B) begin
         rd_val = s_reg.en_b & FB_MASK;
      end else if (s_axi_araddr[9:2] == IDX_CAUSE) begin
         rd_val = s_reg.cause & CAUSE_MASK;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Hardware events, gated only by the capture mode where needed.
   assign set_a = {ev.psp_access,
                   ev.conv_done,
                   2'b00,
                   ev.ssp_event,
                   ev.ccp1_event & ~ev.ccp1_pwm,
                   ev.period_match,
                   ev.t1_overflow};
   assign set_b = {3'b000,
                   ev.ee_done,
                   ev.collision,
                   2'b00,
                   ev.ccp2_event & ~ev.ccp2_pwm};

   // A write is carried out once address and data are both held.
   assign do_wr = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;

   // Next state: bus handshakes, register writes, then hardware events.
   always_comb begin
      s_next = s_reg;
      wr_hit = 1'b1;
      if (s_axi_awvalid && s_reg.awready) begin
         s_next.aw_held = 1'b1;
         s_next.aw_idx  = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_reg.wready) begin
         s_next.w_held = 1'b1;
         s_next.w_data = s_axi_wdata[7:0];
         s_next.w_lane = s_axi_wstrb[0];
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (do_wr) begin
         if (s_reg.aw_idx == IDX_CTRL) begin
            if (s_reg.w_lane) begin
               s_next.ctrl = s_reg.w_data & CTRL_MASK;
            end
         end else if (s_reg.aw_idx == IDX_FLAGS_A) begin
            if (s_reg.w_lane) begin
               s_next.fl_a = (s_reg.w_data & FA_WR_MASK) | (s_reg.fl_a & ~FA_WR_MASK);
            end
         end else if (s_reg.aw_idx == IDX_FLAGS_B) begin
            if (s_reg.w_lane) begin
               s_next.fl_b = s_reg.w_data & FB_MASK;
            end
         end else if (s_reg.aw_idx == IDX_EN_A) begin
            if (s_reg.w_lane) begin
               s_next.en_a = s_reg.w_data;
            end
         end else if (s_reg.aw_idx == IDX_EN_B) begin
            if (s_reg.w_lane) begin
               s_next.en_b = s_reg.w_data & FB_MASK;
            end
         end else if (s_reg.aw_idx == IDX_CAUSE) begin
            if (s_reg.w_lane) begin
               s_next.cause = s_reg.w_data & CAUSE_MASK;
            end
         end else begin
            wr_hit = 1'b0;
         end
         s_next.aw_held = 1'b0;
         s_next.w_held  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      // Events are ORed in after the software write.
      s_next.fl_a = s_next.fl_a | set_a;
      s_next.fl_b = s_next.fl_b | set_b;
      // Buffer state flags follow the transceiver levels.
      s_next.fl_a[FA_RX] = ev.rx_full;
      s_next.fl_a[FA_TX] = ev.tx_empty;
      // Reset causes override software; brown-out ignored when off.
      if (rst_src.por_event) begin
         s_next.cause[RC_POR] = 1'b0;
      end
      if (rst_src.bor_event && rst_src.bod_enable) begin
         s_next.cause[RC_BOR] = 1'b0;
      end
      // Read channel.
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = {24'h00_0000, rd_val};
         s_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      s_next.arready = ~s_next.rvalid;
      s_next.awready = ~s_next.aw_held & ~s_next.bvalid;
      s_next.wready  = ~s_next.w_held & ~s_next.bvalid;
      // Request: enabled flags, gated by peripheral then global enable.
      s_next.irq = s_next.ctrl[CT_GIE] & s_next.ctrl[CT_PERIPHERAL_IRQ_ENABLE] &
                   ((|(s_next.fl_a & s_next.en_a)) | (|(s_next.fl_b & s_next.en_b)));
   end

   // State register with synchronous reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg       <= '0;
         s_reg.ctrl  <= CTRL_RST;
         s_reg.fl_a  <= FLAGS_A_RST;
         s_reg.fl_b  <= FLAGS_B_RST;
         s_reg.en_a  <= EN_A_RST;
         s_reg.en_b  <= EN_B_RST;
         s_reg.cause <= CAUSE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register.
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready  = s_reg.wready;
   assign s_axi_bvalid  = s_reg.bvalid;
   assign s_axi_bresp   = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid  = s_reg.rvalid;
   assign s_axi_rresp   = s_reg.rresp;
   assign s_axi_rdata   = s_reg.rdata;
   assign irq_out       = s_reg.irq;

   // Checks on flag, request and bus behaviour.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_set_beats_clear: assert property (
      ev.period_match |=> s_reg.fl_a[FA_PR])
      else $error("period flag lost against a write");
   chk_psp_sticky: assert property (
      s_reg.fl_a[FA_PSP] && !(do_wr && s_reg.aw_idx == IDX_FLAGS_A) |=> s_reg.fl_a[FA_PSP])
      else $error("parallel flag dropped without a write");
   chk_rx_level: assert property (
      ##1 s_reg.fl_a[FA_RX] == $past(ev.rx_full))
      else $error("receive flag does not follow buffer level");
   chk_ccp_pwm_quiet: assert property (
      !s_reg.fl_a[FA_CCP1] && ev.ccp1_pwm && !do_wr |=> !s_reg.fl_a[FA_CCP1])
      else $error("capture flag set in pwm mode");
   chk_gie_blocks: assert property (
      !s_reg.ctrl[CT_GIE] |-> !irq_out)
      else $error("request with global enable off");
   chk_peripheral_irq_enable_blocks: assert property (
      !s_reg.ctrl[CT_PERIPHERAL_IRQ_ENABLE] |-> !irq_out)
      else $error("request with peripheral enable off");
   chk_irq_raise: assert property (
      s_reg.ctrl[CT_GIE] && s_reg.ctrl[CT_PERIPHERAL_IRQ_ENABLE] && s_reg.en_a[FA_T1] && ev.t1_overflow
      && !do_wr |=> irq_out)
      else $error("enabled overflow did not raise request");
   chk_por_clears: assert property (
      rst_src.por_event |=> !s_reg.cause[RC_POR])
      else $error("power-on status not cleared");
   chk_bor_clears: assert property (
      rst_src.bor_event && rst_src.bod_enable |=> !s_reg.cause[RC_BOR])
      else $error("brown-out status not cleared");
   chk_unimpl_zero: assert property (
      (s_reg.fl_b & ~FB_MASK) == 8'h00 && (s_reg.en_b & ~FB_MASK) == 8'h00)
      else $error("unimplemented bit set");
   chk_write_resp: assert property (
      do_wr |=> s_axi_bvalid ##0 !s_axi_awready)
      else $error("write not answered");
   chk_read_resp: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");

   cov_write: cover property (do_wr ##1 s_axi_bvalid && s_axi_bready);
   cov_read: cover property (s_axi_rvalid && s_axi_rready);
   cov_irq: cover property (!irq_out ##1 irq_out);
   cov_collision: cover property (ev.collision ##1 s_reg.fl_b[FB_COL]);
   cov_set_wins: cover property (do_wr && ev.period_match);

   // Per-flag set checks: every event lands in its flag one cycle later, a capture or compare event only outside PWM mode.

   // A parallel port access raises its flag.
   chk_psp_set: assert property (
      ev.psp_access |=> s_reg.fl_a[FA_PSP])
      else $error("parallel flag not set");

   // A finished conversion raises its flag.
   chk_conv_set: assert property (
      ev.conv_done |=> s_reg.fl_a[FA_CONV])
      else $error("conversion flag not set");

   // A serial port event raises its flag.
   chk_ssp_set: assert property (
      ev.ssp_event |=> s_reg.fl_a[FA_SSP])
      else $error("serial flag not set");

   // A capture or compare outside PWM mode raises its flag.
   chk_ccp1_set: assert property (
      ev.ccp1_event && !ev.ccp1_pwm |=> s_reg.fl_a[FA_CCP1])
      else $error("capture one flag not set");

   // A timer one overflow raises its flag.
   chk_t1_set: assert property (
      ev.t1_overflow |=> s_reg.fl_a[FA_T1])
      else $error("overflow flag not set");

   // A finished EEPROM write raises its flag.
   chk_ee_set: assert property (
      ev.ee_done |=> s_reg.fl_b[FB_EE])
      else $error("eeprom flag not set");

   // A bus collision raises its flag.
   chk_col_set: assert property (
      ev.collision |=> s_reg.fl_b[FB_COL])
      else $error("collision flag not set");

   // The second capture unit outside PWM mode raises its flag.
   chk_ccp2_set: assert property (
      ev.ccp2_event && !ev.ccp2_pwm |=> s_reg.fl_b[FB_CCP2])
      else $error("capture two flag not set");

   // Level and mode checks.

   // The transmit flag mirrors the transmit buffer level.
   chk_tx_level: assert property (
      ##1 s_reg.fl_a[FA_TX] == $past(ev.tx_empty))
      else $error("transmit flag does not follow buffer level");

   // The second capture unit stays quiet in PWM mode.
   chk_ccp2_pwm_quiet: assert property (
      !s_reg.fl_b[FB_CCP2] && ev.ccp2_pwm && !do_wr |=> !s_reg.fl_b[FB_CCP2])
      else $error("capture two flag set in pwm mode");

   // Stickiness: only a software write may drop a set flag.

   // The period match flag holds until written.
   chk_period_sticky: assert property (
      s_reg.fl_a[FA_PR] && !(do_wr && s_reg.aw_idx == IDX_FLAGS_A) |=> s_reg.fl_a[FA_PR])
      else $error("period flag dropped without a write");

   // The overflow flag holds until written.
   chk_t1_sticky: assert property (
      s_reg.fl_a[FA_T1] && !(do_wr && s_reg.aw_idx == IDX_FLAGS_A) |=> s_reg.fl_a[FA_T1])
      else $error("overflow flag dropped without a write");

   // The EEPROM flag holds until written.
   chk_ee_sticky: assert property (
      s_reg.fl_b[FB_EE] && !(do_wr && s_reg.aw_idx == IDX_FLAGS_B) |=> s_reg.fl_b[FB_EE])
      else $error("eeprom flag dropped without a write");

   // The collision flag holds until written.
   chk_col_sticky: assert property (
      s_reg.fl_b[FB_COL] && !(do_wr && s_reg.aw_idx == IDX_FLAGS_B) |=> s_reg.fl_b[FB_COL])
      else $error("collision flag dropped without a write");

   // The EEPROM flag stays clear while no write finishes.
   chk_ee_idle: assert property (
      !s_reg.fl_b[FB_EE] && !ev.ee_done && !(do_wr && s_reg.aw_idx == IDX_FLAGS_B)
      |=> !s_reg.fl_b[FB_EE])
      else $error("eeprom flag set without a finished write");

   // Software can clear the parallel flag when no access collides.
   chk_psp_clear: assert property (
      do_wr && s_reg.aw_idx == IDX_FLAGS_A && s_reg.w_lane && !s_reg.w_data[FA_PSP]
      && !ev.psp_access |=> !s_reg.fl_a[FA_PSP])
      else $error("parallel flag not cleared by software");

   // Register write checks.

   // Enable register A takes the written byte whole.
   chk_en_a_write: assert property (
      do_wr && s_reg.aw_idx == IDX_EN_A && s_reg.w_lane |=> s_reg.en_a == $past(s_reg.w_data))
      else $error("enable a write lost");

   // Enable register B keeps only its implemented bits.
   chk_en_b_write: assert property (
      do_wr && s_reg.aw_idx == IDX_EN_B && s_reg.w_lane
      |=> s_reg.en_b == ($past(s_reg.w_data) & FB_MASK))
      else $error("enable b write wrong");

   // A write with its byte lane off leaves the register alone.
   chk_strb_hold: assert property (
      do_wr && s_reg.aw_idx == IDX_EN_A && !s_reg.w_lane |=> $stable(s_reg.en_a))
      else $error("masked write changed enable a");

   // With detection off a brown-out leaves its status bit alone.
   chk_bor_off: assert property (
      rst_src.bor_event && !rst_src.bod_enable && !(do_wr && s_reg.aw_idx == IDX_CAUSE)
      |=> $stable(s_reg.cause[RC_BOR]))
      else $error("brown-out bit moved with detection off");

   // Read data carries nothing above the register byte.
   chk_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read data not zero");

   // Request output checks.

   // The request equals the gated OR of enabled flags.
   chk_irq_exact: assert property (
      irq_out == (s_reg.ctrl[CT_GIE] && s_reg.ctrl[CT_PERIPHERAL_IRQ_ENABLE]
                  && ((|(s_reg.fl_a & s_reg.en_a)) || (|(s_reg.fl_b & s_reg.en_b)))))
      else $error("request does not match enabled flags");

   // Bus handshake checks.

   // After a write response both write channels reopen.
   chk_ready_return: assert property (
      s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
      else $error("write channels did not reopen");

   // After a read is taken the address channel reopens.
   chk_rvalid_drop: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel did not reopen");
endmodule // pif_top

// ---- tb/pif_periph_model.sv ----
// Behavioural model of the peripherals and reset sources that feed the flag block.
`timescale 1ns/1ns
module pif_periph_model (
   input  wire logic             aclk,
   output pif_pkg::pif_events_t  ev,
   output pif_pkg::pif_rst_src_t rst_src
);
   import pif_pkg::*;
   pif_events_t  pulse_reg = '0;
   pif_events_t  level_reg = '0;
   pif_rst_src_t rst_reg   = '0;
   // Pulses last one cycle and ride on top of the held levels.
   assign ev      = pulse_reg | level_reg;
   assign rst_src = rst_reg;
   // A peripheral reports one event as a single-cycle pulse.
   task automatic fire(input pif_events_t m);
      @(posedge aclk);
      pulse_reg <= m;
      @(posedge aclk);
      pulse_reg <= '0;
   endtask
   // Level conditions such as buffer state or PWM mode persist until changed.
   task automatic hold(input pif_events_t m);
      @(posedge aclk);
      level_reg <= m;
   endtask
   // A reset source pulses while detection enable stays as a level.
   task automatic cause(input pif_rst_src_t m);
      @(posedge aclk);
      rst_reg <= m;
      @(posedge aclk);
      rst_reg <= {2'b00, m.bod_enable};
   endtask
endmodule // pif_periph_model

// ---- tb/tb.sv ----
// Self-checking bench for the peripheral flag block.
`timescale 1ns/1ns
module tb;
   import pif_pkg::*;
   localparam int         LIMIT = 4000;
   localparam logic [9:0] A_FA  = {IDX_FLAGS_A, 2'b00};
   localparam logic [9:0] A_FB  = {IDX_FLAGS_B, 2'b00};
   localparam logic [9:0] A_EA  = {IDX_EN_A, 2'b00};
   localparam logic [9:0] A_EB  = {IDX_EN_B, 2'b00};
   localparam logic [9:0] A_RC  = {IDX_CAUSE, 2'b00};
   localparam logic [9:0] A_CT  = {IDX_CTRL, 2'b00};
   localparam logic [9:0] A_BAD = 10'h3fc;
   localparam logic [1:0] OK    = RESP_OKAY;
   logic aclk = 1'b0;
   logic aresetn;
   logic [9:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [9:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   pif_events_t ev;
   pif_rst_src_t rst_src;
   logic irq_out;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   // Each single event and the flag bits it should raise.
   pif_events_t ev_tab [9] = '{13'h1000, 13'h0800, 13'h0100, 13'h0080, 13'h0020,
                               13'h0010, 13'h0008, 13'h0004, 13'h0002};
   logic [7:0] fa_tab [9] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00};
   logic [7:0] fb_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h08, 8'h01};

   pif_top u_pif_top (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev, .rst_src, .irq_out);
   pif_periph_model u_pif_periph_model (.aclk, .ev, .rst_src);

   // Free-running clock and a cycle ceiling that cuts a hang short.
   always #20 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         final_report();
      end
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Write cycle: address and data offered together, each released once taken.
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
      chk_val({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   // Read cycle: data and response taken at the edge that shows rvalid.
   task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
      chk_val(s_axi_rdata, {24'h00_0000, d});
      chk_val({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   // The request is registered in the same cycle as the flags; still let two edges pass first.
   task automatic irq_is(input logic e);
      repeat (2) @(posedge aclk);
      #1;
      chk_val({31'h0, irq_out}, {31'h0, e});
   endtask
   task automatic final_report();
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Main sequence of register and event scenarios.
   initial begin
      aresetn <= 1'b0;
      s_axi_awaddr <= '0;
      s_axi_awvalid <= 1'b0;
      s_axi_wdata <= '0;
      s_axi_wstrb <= '0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_araddr <= '0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_FA, 8'h00, OK);
      rd(A_FB, 8'h00, OK);
      rd(A_EA, 8'h00, OK);
      rd(A_EB, 8'h00, OK);
      rd(A_RC, 8'h01, OK);
      rd(A_CT, 8'h00, OK);
      rd(A_BAD, 8'h00, RESP_SLVERR);
      wr(A_BAD, 8'hff, 4'h1, RESP_SLVERR);
      for (int i = 0; i < 9; i++) begin
         u_pif_periph_model.fire(ev_tab[i]);
         rd(A_FA, fa_tab[i], OK);
         rd(A_FB, fb_tab[i], OK);
         wr(A_FA, 8'h00, 4'h1, OK);
         wr(A_FB, 8'h00, 4'h1, OK);
      end
      u_pif_periph_model.hold(13'h0400);
      rd(A_FA, 8'h20, OK);
      u_pif_periph_model.hold(13'h0200);
      wr(A_FA, 8'h00, 4'h1, OK);
      rd(A_FA, 8'h10, OK);
      u_pif_periph_model.hold(13'h0041);
      u_pif_periph_model.fire(13'h0082);
      rd(A_FA, 8'h00, OK);
      rd(A_FB, 8'h00, OK);
      u_pif_periph_model.hold(13'h0000);
      wr(A_EA, 8'hff, 4'h1, OK);
      rd(A_EA, 8'hff, OK);
      wr(A_EA, 8'h00, 4'h0, OK);
      rd(A_EA, 8'hff, OK);
      wr(A_EB, 8'hbf, 4'h1, OK);
      rd(A_EB, 8'h19, OK);
      wr(A_FB, 8'hbf, 4'h1, OK);
      rd(A_FB, 8'h19, OK);
      wr(A_FB, 8'h00, 4'h1, OK);
      wr(A_EB, 8'h00, 4'h1, OK);
      wr(A_EA, 8'h01, 4'h1, OK);
      u_pif_periph_model.fire(13'h0010);
      wr(A_CT, 8'h80, 4'h1, OK);
      irq_is(1'b0);
      wr(A_CT, 8'h40, 4'h1, OK);
      irq_is(1'b0);
      wr(A_CT, 8'hc0, 4'h1, OK);
      irq_is(1'b1);
      wr(A_EA, 8'h00, 4'h1, OK);
      irq_is(1'b0);
      wr(A_FA, 8'h00, 4'h1, OK);
      wr(A_EA, 8'h01, 4'h1, OK);
      u_pif_periph_model.fire(13'h0010);
      irq_is(1'b1);
      wr(A_EA, 8'h00, 4'h1, OK);
      wr(A_FA, 8'h00, 4'h1, OK);
      wr(A_EB, 8'h10, 4'h1, OK);
      u_pif_periph_model.fire(13'h0008);
      irq_is(1'b1);
      wr(A_FB, 8'h00, 4'h1, OK);
      irq_is(1'b0);
      fork
         wr(A_FA, 8'h00, 4'h1, OK);
         begin
            @(posedge aclk);
            u_pif_periph_model.fire(13'h0020);
         end
      join
      rd(A_FA, 8'h02, OK);
      wr(A_RC, 8'hff, 4'h1, OK);
      rd(A_RC, 8'h03, OK);
      u_pif_periph_model.cause(3'b100);
      rd(A_RC, 8'h01, OK);
      wr(A_RC, 8'h03, 4'h1, OK);
      u_pif_periph_model.cause(3'b011);
      rd(A_RC, 8'h02, OK);
      final_report();
   end
endmodule // tb
